/* logic/pss_pkg.sv */
// Purpose: Constants and types for the panel supply start-up sequencer
// Assumes: 125 MHz system clock, comparator flags from the analog front end
// Notes:   Soft-start and fault counts derive from times in milliseconds

package pss_pkg;

    //*****************************************************************
    // Timing
    //*****************************************************************
    localparam int CLK_MHZ      = 125;
    localparam int SOFTSTART_MS = 14;
    localparam int FAULT_MS     = 55;
    localparam int SS_CYCLES    = SOFTSTART_MS * 1000 * CLK_MHZ;
    localparam int FAULT_CYCLES = FAULT_MS * 1000 * CLK_MHZ;
    localparam int DAC_STEPS    = 128;
    localparam int PEAK_CURRENT_LIMIT_STEPS   = 8;
    localparam int STEP_CYCLES  = SS_CYCLES / DAC_STEPS;
    localparam int STEPS_PER_PEAK_CURRENT_LIMIT = DAC_STEPS / PEAK_CURRENT_LIMIT_STEPS;

    //*****************************************************************
    // Levels
    //*****************************************************************
    localparam int       REF_MV      = 1250;
    localparam int       GOFF_END_MV = 250;
    localparam logic [6:0] DAC_TOP   = 7'h7F;
    localparam logic [6:0] GOFF_END  = 7'(DAC_STEPS * GOFF_END_MV / REF_MV);
    localparam logic [7:0] STEP_LAST = 8'h80;
    localparam logic [3:0] PEAK_CURRENT_LIMIT_FULL = 4'h8;

    //*****************************************************************
    // Register map
    //*****************************************************************
    localparam logic [11:0] OFS_CTRL   = 12'h000;
    localparam logic [11:0] OFS_STATUS = 12'h004;
    localparam logic [11:0] OFS_DACS   = 12'h008;
    localparam int          CTRL_START_BIT = 0;
    localparam logic        CTRL_RESET     = 1'b1;

    //*****************************************************************
    // Types
    //*****************************************************************
    typedef struct packed {
        logic supplyAbove1v7;
        logic uvloAboveRise;
        logic uvloAboveFall;
        logic refAbove1v0;
        logic boostInReg;
        logic gateOnInReg;
        logic gateOffInReg;
        logic delayAbove1v25;
        logic thermalHot;
        logic switchSelect;
    } pss_cmp_t;

    typedef enum logic [2:0] {
        S_LOCKOUT, S_REF_WAIT, S_SOFTSTART, S_DELAY, S_ACTIVE, S_FAULT
    } pss_state_t;

endpackage : pss_pkg

/* logic/pss_sequencer.sv */
// Purpose: Start-up, soft-start, delay and protection sequencer
// Assumes: Comparator flags are asynchronous; APB slave answers with no wait
// Notes:   Analog loops are outside; this block drives only enables, codes, switch controls and the fault flag
`timescale 1ns/1ps
`default_nettype none

module pss_sequencer #(
    parameter int STEP_CYCLES  = pss_pkg::STEP_CYCLES,
    parameter int FAULT_CYCLES = pss_pkg::FAULT_CYCLES,
    parameter int CNT_W        = 24
) (
    // Clock and reset
    input  wire logic             sys_clk,
    input  wire logic             arst_n,
    // APB slave
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [11:0]      paddr,
    input  wire logic [31:0]      pwdata,
    input  wire logic [3:0]       pstrb,
    output logic [31:0]           prdata,
    output logic                  pready,
    output logic                  pslverr,
    // Comparator flags from the analog front end
    input  wire pss_pkg::pss_cmp_t cmpIn,
    // Regulator controls
    output logic                  refEnable,
    output logic                  boostEnable,
    output logic                  gateOnEnable,
    output logic                  gateOffEnable,
    output logic [3:0]            peakCurrentLimit,
    output logic [6:0]            gateOnDac,
    output logic [6:0]            gateOffDac,
    // Delay capacitor and switch block
    output logic                  delayCapCharge,
    output logic                  delayCapDischarge,
    output logic                  sourceSideSwitchOn,
    output logic                  drainSideSwitchOn,
    output logic                  comPullDown,
    output logic                  ampOutputHiZ,
    output logic                  faultLatched
);

    //*****************************************************************
    // Helpers
    //*****************************************************************
    // Gate-off code falls linearly from the top to the 250 mV code
    function automatic logic [6:0] offDac(input logic [7:0] step);
        logic [15:0] drop;
        // Product is formed at 16 bits so the top steps do not wrap
        drop = (16'(pss_pkg::DAC_TOP - pss_pkg::GOFF_END) * 16'(step)) >> $clog2(pss_pkg::DAC_STEPS);
        return 7'(pss_pkg::DAC_TOP - drop[6:0]);
    endfunction : offDac

    //*****************************************************************
    // Input synchroniser
    //*****************************************************************
    pss_pkg::pss_cmp_t syncA_reg;
    pss_pkg::pss_cmp_t syncB_reg;
    pss_pkg::pss_cmp_t syncC_reg;
    pss_pkg::pss_cmp_t flt_reg;

    // Three stages; a flag changes once the last two agree
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            syncA_reg <= '0;
            syncB_reg <= '0;
            syncC_reg <= '0;
            flt_reg   <= '0;
        end else begin
            syncA_reg <= cmpIn;
            syncB_reg <= syncA_reg;
            syncC_reg <= syncB_reg;
            flt_reg   <= (syncB_reg & syncC_reg) | (flt_reg & (syncB_reg ^ syncC_reg));
        end
    end

    //*****************************************************************
    // Lockout, fault and state
    //*****************************************************************
    logic                    lockout_reg;
    logic                    fault_reg;
    logic                    startEn_reg;
    logic                    boostDone_reg;
    logic [7:0]              step_reg;
    logic [CNT_W-1:0]        stepTmr_reg;
    logic [CNT_W-1:0]        faultTmr_reg;
    pss_pkg::pss_state_t     state_reg;
    pss_pkg::pss_state_t     state_next;
    logic                    regsOn;
    logic                    postSoftStart;
    logic                    regLow;
    logic                    switchActive;
    logic                    faultTimeUp;

    // Hysteresis: release on rising crossing, assert below falling one
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            lockout_reg <= 1'b1;
        end else if (!flt_reg.uvloAboveFall) begin
            lockout_reg <= 1'b1;
        end else if (flt_reg.uvloAboveRise) begin
            lockout_reg <= 1'b0;
        end
    end

    assign regLow      = !flt_reg.boostInReg || !flt_reg.gateOnInReg || !flt_reg.gateOffInReg;
    assign faultTimeUp = faultTmr_reg == CNT_W'(FAULT_CYCLES - 1);

    // Fault timer runs only after soft-start while an output is low
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            faultTmr_reg <= '0;
        end else if (postSoftStart && regLow && !faultTimeUp) begin
            faultTmr_reg <= faultTmr_reg + CNT_W'(1);
        end else if (!(postSoftStart && regLow)) begin
            faultTmr_reg <= '0;
        end
    end

    // Fault latch; only a lockout clears it
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            fault_reg <= 1'b0;
        end else if (lockout_reg) begin
            fault_reg <= 1'b0;
        end else if (flt_reg.thermalHot) begin
            fault_reg <= 1'b1;
        end else if (faultTimeUp) begin
            fault_reg <= 1'b1;
        end
    end

    // Next state
    always_comb begin
        state_next = state_reg;
        if (lockout_reg) begin
            state_next = pss_pkg::S_LOCKOUT;
        end else if (fault_reg) begin
            state_next = pss_pkg::S_FAULT;
        end else begin
            unique case (state_reg)
                pss_pkg::S_LOCKOUT:   state_next = pss_pkg::S_REF_WAIT;
                pss_pkg::S_REF_WAIT: begin
                    if (flt_reg.refAbove1v0 && startEn_reg) begin
                        state_next = pss_pkg::S_SOFTSTART;
                    end
                end
                pss_pkg::S_SOFTSTART: begin
                    if (step_reg == pss_pkg::STEP_LAST) begin
                        state_next = pss_pkg::S_DELAY;
                    end
                end
                pss_pkg::S_DELAY: begin
                    if (flt_reg.delayAbove1v25) begin
                        state_next = pss_pkg::S_ACTIVE;
                    end
                end
                pss_pkg::S_ACTIVE:    state_next = pss_pkg::S_ACTIVE;
                pss_pkg::S_FAULT:     state_next = pss_pkg::S_FAULT;
            endcase
        end
    end

    // State register
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= pss_pkg::S_LOCKOUT;
        end else begin
            state_reg <= state_next;
        end
    end

    //*****************************************************************
    // Soft-start ramps
    //*****************************************************************
    // Step timer divides 14 ms into 128 DAC steps
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            stepTmr_reg <= '0;
            step_reg    <= '0;
        end else if (state_reg != pss_pkg::S_SOFTSTART) begin
            stepTmr_reg <= '0;
            if (!postSoftStart) begin
                step_reg <= '0;
            end
        end else if (stepTmr_reg == CNT_W'(STEP_CYCLES - 1)) begin
            stepTmr_reg <= '0;
            if (step_reg != pss_pkg::STEP_LAST) begin
                step_reg <= step_reg + 8'h01;
            end
        end else begin
            stepTmr_reg <= stepTmr_reg + CNT_W'(1);
        end
    end

    // Boost soft-start ends on regulation or timer expiry
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            boostDone_reg <= 1'b0;
        end else if (!regsOn) begin
            boostDone_reg <= 1'b0;
        end else if (flt_reg.boostInReg || step_reg == pss_pkg::STEP_LAST) begin
            boostDone_reg <= 1'b1;
        end
    end

    //*****************************************************************
    // Outputs
    //*****************************************************************
    assign regsOn        = state_reg == pss_pkg::S_SOFTSTART || postSoftStart;
    assign postSoftStart = state_reg == pss_pkg::S_DELAY || state_reg == pss_pkg::S_ACTIVE;
    assign switchActive  = state_reg == pss_pkg::S_ACTIVE;

    // Regulator enables and codes
    assign refEnable        = flt_reg.supplyAbove1v7;
    assign boostEnable      = regsOn;
    assign gateOnEnable     = regsOn;
    assign gateOffEnable    = regsOn;
    assign peakCurrentLimit = boostDone_reg ? pss_pkg::PEAK_CURRENT_LIMIT_FULL
                            : 4'(step_reg / 8'(pss_pkg::STEPS_PER_PEAK_CURRENT_LIMIT));
    assign gateOnDac        = step_reg == pss_pkg::STEP_LAST ? pss_pkg::DAC_TOP : step_reg[6:0];
    assign gateOffDac       = offDac(step_reg);

    // Delay capacitor and switch block
    assign delayCapCharge     = postSoftStart;
    assign delayCapDischarge  = !postSoftStart;
    assign sourceSideSwitchOn = switchActive && flt_reg.switchSelect;
    assign drainSideSwitchOn  = switchActive && !flt_reg.switchSelect;
    assign comPullDown        = !switchActive;
    assign ampOutputHiZ       = lockout_reg || fault_reg;
    assign faultLatched       = fault_reg;

    //*****************************************************************
    // APB slave
    //*****************************************************************
    logic        mapped;
    logic [31:0] rdValue;
    logic [31:0] prdata_reg;

    assign mapped  = paddr == pss_pkg::OFS_CTRL || paddr == pss_pkg::OFS_STATUS
                  || paddr == pss_pkg::OFS_DACS;
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign prdata  = prdata_reg;

    // Read mux
    always_comb begin
        rdValue = '0;
        unique case (paddr)
            pss_pkg::OFS_CTRL:   rdValue = {31'h00000000, startEn_reg};
            pss_pkg::OFS_STATUS: rdValue = {16'h0000, step_reg, 1'b0, state_reg,
                                            boostDone_reg, switchActive, fault_reg, lockout_reg};
            pss_pkg::OFS_DACS:   rdValue = {12'h000, peakCurrentLimit, 1'b0, gateOffDac, 1'b0, gateOnDac};
            default:             rdValue = '0;
        endcase
    end

    // Read data captured in the setup cycle
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            prdata_reg <= '0;
        end else if (psel && !penable && !pwrite) begin
            prdata_reg <= rdValue;
        end
    end

    // Control register; start gate for the regulators
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            startEn_reg <= pss_pkg::CTRL_RESET;
        end else if (psel && penable && pwrite && paddr == pss_pkg::OFS_CTRL && pstrb[0]) begin
            startEn_reg <= pwdata[pss_pkg::CTRL_START_BIT];
        end
    end

    //*****************************************************************
    // Assertions
    //*****************************************************************
    property p_enable_together;
        @(posedge sys_clk) disable iff (!arst_n)
        $rose(boostEnable) |-> $rose(gateOnEnable) && $rose(gateOffEnable) && $past(flt_reg.refAbove1v0);
    endproperty
    a_enable_together: assert property (p_enable_together) else $error("regulators not enabled together");

    property p_peak_current_limit_steps;
        @(posedge sys_clk) disable iff (!arst_n)
        !boostDone_reg |-> peakCurrentLimit == 4'(step_reg >> 4);
    endproperty
    a_peak_current_limit_steps: assert property (p_peak_current_limit_steps) else $error("current limit not in eighths");

    property p_boost_end;
        @(posedge sys_clk) disable iff (!arst_n)
        (state_reg == pss_pkg::S_SOFTSTART && flt_reg.boostInReg && !lockout_reg && !fault_reg)
            |=> peakCurrentLimit == pss_pkg::PEAK_CURRENT_LIMIT_FULL;
    endproperty
    a_boost_end: assert property (p_boost_end) else $error("boost soft-start did not end");

    property p_dac_restart;
        @(posedge sys_clk) disable iff (!arst_n)
        $rose(gateOnEnable) |-> gateOnDac == 7'h00 && gateOffDac == pss_pkg::DAC_TOP;
    endproperty
    a_dac_restart: assert property (p_dac_restart) else $error("DAC ramp not restarted");

    property p_ramp_ends;
        @(posedge sys_clk) disable iff (!arst_n)
        $rose(delayCapCharge) |-> gateOnDac == pss_pkg::DAC_TOP && gateOffDac == pss_pkg::GOFF_END;
    endproperty
    a_ramp_ends: assert property (p_ramp_ends) else $error("DAC ramps incomplete");

    property p_lockout_off;
        @(posedge sys_clk) disable iff (!arst_n)
        lockout_reg |-> ampOutputHiZ ##1 (!boostEnable && comPullDown && delayCapDischarge);
    endproperty
    a_lockout_off: assert property (p_lockout_off) else $error("outputs live in lockout");

    property p_switch_sel;
        @(posedge sys_clk) disable iff (!arst_n)
        switchActive |-> sourceSideSwitchOn == flt_reg.switchSelect && drainSideSwitchOn == !flt_reg.switchSelect;
    endproperty
    a_switch_sel: assert property (p_switch_sel) else $error("switch does not follow select");

    property p_switch_idle;
        @(posedge sys_clk) disable iff (!arst_n)
        !(postSoftStart && flt_reg.delayAbove1v25) ##1 !switchActive |-> comPullDown && !sourceSideSwitchOn
            && !drainSideSwitchOn;
    endproperty
    a_switch_idle: assert property (p_switch_idle) else $error("switch on while inactive");

    property p_thermal;
        @(posedge sys_clk) disable iff (!arst_n)
        flt_reg.thermalHot && !lockout_reg |=> faultLatched ##1 !boostEnable;
    endproperty
    a_thermal: assert property (p_thermal) else $error("thermal fault not latched");

    property p_fault_hold;
        @(posedge sys_clk) disable iff (!arst_n)
        faultLatched && !lockout_reg |=> faultLatched;
    endproperty
    a_fault_hold: assert property (p_fault_hold) else $error("fault latch cleared early");

    property p_no_fault_in_ss;
        @(posedge sys_clk) disable iff (!arst_n)
        state_reg == pss_pkg::S_SOFTSTART |-> faultTmr_reg == '0;
    endproperty
    a_no_fault_in_ss: assert property (p_no_fault_in_ss) else $error("fault timer ran in soft-start");

    c_active:    cover property (@(posedge sys_clk) disable iff (!arst_n) $rose(switchActive));
    c_fault:     cover property (@(posedge sys_clk) disable iff (!arst_n) $rose(faultLatched));
    c_sel_high:  cover property (@(posedge sys_clk) disable iff (!arst_n) sourceSideSwitchOn);

endmodule : pss_sequencer

`default_nettype wire

/* tb/pss_panel_ctrl.sv */
// Purpose: Panel controller model that drives the switch select level
// Assumes: Select is a plain level that changes only after a rising edge
// Notes:   The level asked for by the bench appears one edge later
`timescale 1ns/1ps
`default_nettype none
module pss_panel_ctrl (
    // Clock and reset
    input  wire logic sys_clk,
    input  wire logic arst_n,
    // Requested and driven select level
    input  wire logic selWanted,
    output logic      switchSelect
);
    // Select register, low out of reset
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            switchSelect <= 1'b0;
        end else begin
            switchSelect <= selWanted;
        end
    end
endmodule : pss_panel_ctrl
`default_nettype wire

/* tb/pss_sequencer_tb_top.sv */
// Purpose: Self-checking bench for the start-up sequencer
// Assumes: Short step and fault counts so a full start-up fits a short run
// Notes:   Outputs are sampled on the falling edge, inputs driven on the rising
`timescale 1ns/1ps
`default_nettype none
module pss_sequencer_tb_top;
    localparam int STEP = 4;
    localparam int FLT  = 50;
    logic sys_clk, arst_n, psel, penable, pwrite, selWanted, sel, chkSw, swAct;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q, rng;
    logic [3:0]  pstrb, peakCurrentLimit;
    logic pready, pslverr, e, refEnable, boostEnable, gateOnEnable, gateOffEnable;
    logic [6:0]  gateOnDac, gateOffDac;
    logic delayCapCharge, delayCapDischarge, sourceSideSwitchOn, drainSideSwitchOn;
    logic comPullDown, ampOutputHiZ, faultLatched;
    pss_pkg::pss_cmp_t cmp, cmpBus;
    int errors, checks, n, stab;
    assign cmpBus = {cmp[9:1], sel};
    pss_sequencer #(.STEP_CYCLES(STEP), .FAULT_CYCLES(FLT)) u_dut (.sys_clk(sys_clk), .arst_n(arst_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .cmpIn(cmpBus), .refEnable(refEnable),
        .boostEnable(boostEnable), .gateOnEnable(gateOnEnable), .gateOffEnable(gateOffEnable),
        .peakCurrentLimit(peakCurrentLimit), .gateOnDac(gateOnDac), .gateOffDac(gateOffDac),
        .delayCapCharge(delayCapCharge), .delayCapDischarge(delayCapDischarge),
        .sourceSideSwitchOn(sourceSideSwitchOn), .drainSideSwitchOn(drainSideSwitchOn),
        .comPullDown(comPullDown), .ampOutputHiZ(ampOutputHiZ), .faultLatched(faultLatched));
    pss_panel_ctrl u_panel (.sys_clk(sys_clk), .arst_n(arst_n), .selWanted(selWanted), .switchSelect(sel));
    //**********************************************************
    // Helpers
    //**********************************************************
    always #4 sys_clk = ~sys_clk;
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : xs
    // Gate-off code at the end of its ramp, scaled from 250 mV of a 1250 mV reference
    function automatic logic [31:0] goffEnd();
        return 32'(128 * 250 / 1250);
    endfunction : goffEnd
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %s expected %0h seen %0h", nm, exp, got);
        end
    endtask : chk
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge sys_clk);
        psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        k = 0;
        do begin @(posedge sys_clk); k++; end while (pready !== 1'b1 && k < 20);
        q = prdata;
        e = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb
    // Random select stretches, each held long enough to settle
    task automatic selRun(input int cnt);
        repeat (cnt) begin
            rng = xs(rng);
            @(posedge sys_clk);
            selWanted <= rng[0];
            repeat (9 + rng[3:1]) @(posedge sys_clk);
        end
    endtask : selRun
    // Follows one soft-start ramp to its end; early raises boost regulation midway
    task automatic ramp(input logic early);
        logic [3:0] pv;
        pv = 4'h0;
        for (n = 0; n < 700 && delayCapCharge !== 1'b1; n++) begin
            @(negedge sys_clk);
            if (n < 300) chk("ilimStep", 1, 32'(peakCurrentLimit >= pv && peakCurrentLimit - pv <= 1));
            pv = peakCurrentLimit;
            if (early && n == 300) begin @(posedge sys_clk); cmp.boostInReg <= 1'b1; end
            if (early && n == 312) chk("ilimReg", 8, peakCurrentLimit);
        end
        chk("ssLen", 1, 32'(n >= 128 * STEP - 4 && n <= 128 * STEP + 8));
        chk("gonEnd", 32'h7F, gateOnDac);
        chk("goffEnd", goffEnd(), gateOffDac);
        chk("ilimEnd", 8, peakCurrentLimit);
        chk("noFltSs", 0, faultLatched);
        @(posedge sys_clk);
        cmp.boostInReg <= 1'b1; cmp.gateOnInReg <= 1'b1; cmp.gateOffInReg <= 1'b1;
    endtask : ramp
    task automatic conclude();
        $display("checks=%0d errors=%0d", checks, errors);
        if (errors == 0 && checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : conclude
    // Switch outputs against the settled select level
    always @(negedge sys_clk) begin
        stab = (sel === u_panel.selWanted) ? stab + 1 : 0;
        if (chkSw && stab == 8) begin
            chk("srcSw", 32'(swAct & sel), 32'(sourceSideSwitchOn));
            chk("drnSw", 32'(swAct & !sel), 32'(drainSideSwitchOn));
            chk("comPd", 32'(!swAct), 32'(comPullDown));
        end
    end
    initial begin
        repeat (20000) @(posedge sys_clk);
        errors++;
        conclude();
    end
    //**********************************************************
    // Main sequence
    //**********************************************************
    initial begin
        sys_clk = 0; arst_n = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; pstrb = 4'hF;
        cmp = '0; selWanted = 0; chkSw = 0; swAct = 0; stab = 0; rng = 32'h86D07687; errors = 0; checks = 0;
        repeat (2) @(posedge sys_clk);
        arst_n <= 1'b1;
        @(negedge sys_clk);
        chk("hiZ0", 1, ampOutputHiZ);
        chk("dis0", 1, delayCapDischarge);
        chk("pd0", 1, comPullDown);
        @(posedge sys_clk);
        cmp.supplyAbove1v7 <= 1'b1; cmp.uvloAboveFall <= 1'b1; cmp.refAbove1v0 <= 1'b1;
        repeat (20) @(negedge sys_clk);
        chk("ref", 1, refEnable);
        chk("noRise", 0, boostEnable);
        apb(1'b0, 12'h000, 32'h0);
        chk("ctrlRst", 1, q);
        apb(1'b1, 12'h000, 32'h0);
        @(posedge sys_clk);
        cmp.uvloAboveRise <= 1'b1;
        repeat (20) @(negedge sys_clk);
        chk("held", 0, boostEnable);
        apb(1'b1, 12'h000, 32'h1);
        for (n = 0; n < 40 && boostEnable !== 1'b1; n++) @(negedge sys_clk);
        chk("gonEn", 1, {boostEnable, gateOnEnable, gateOffEnable} == 3'b111);
        chk("dacs", 32'h007F, {gateOnDac, 1'b0, gateOffDac});
        ramp(1'b1);
        chkSw = 1;
        selRun(6);
        chkSw = 0;
        @(posedge sys_clk);
        cmp.delayAbove1v25 <= 1'b1;
        repeat (12) @(negedge sys_clk);
        chk("swOn", 1, 32'(sourceSideSwitchOn | drainSideSwitchOn));
        swAct = 1; chkSw = 1;
        selRun(20);
        apb(1'b0, 12'h004, 32'h0);
        chk("stState", 32'h4, 32'(q[6:4]));
        apb(1'b0, 12'h008, 32'h0);
        chk("dacsReg", 32'h0008197F, q);
        apb(1'b0, 12'hFFC, 32'h0);
        chk("badErr", 1, 32'(e));
        chk("badRd", 0, q);
        chkSw = 0; swAct = 0;
        @(posedge sys_clk);
        cmp.gateOnInReg <= 1'b0;
        for (n = 0; n < 90 && faultLatched !== 1'b1; n++) @(negedge sys_clk);
        chk("fltTime", 1, 32'(n >= FLT - 2 && n <= FLT + 10));
        repeat (3) @(negedge sys_clk);
        chk("fltOut", 32'h0F, {boostEnable, refEnable, ampOutputHiZ, delayCapDischarge, comPullDown});
        @(posedge sys_clk);
        cmp.gateOnInReg <= 1'b1;
        repeat (20) @(negedge sys_clk);
        chk("fltHold", 1, faultLatched);
        @(posedge sys_clk);
        cmp.uvloAboveFall <= 1'b0; cmp.uvloAboveRise <= 1'b0;
        cmp.boostInReg <= 1'b0; cmp.gateOnInReg <= 1'b0; cmp.gateOffInReg <= 1'b0;
        repeat (12) @(negedge sys_clk);
        chk("lockClr", 32'h03, {faultLatched, boostEnable, ampOutputHiZ, delayCapDischarge});
        @(posedge sys_clk);
        cmp.uvloAboveFall <= 1'b1; cmp.uvloAboveRise <= 1'b1;
        for (n = 0; n < 40 && boostEnable !== 1'b1; n++) @(negedge sys_clk);
        chk("dacs2", 32'h007F, {gateOnDac, 1'b0, gateOffDac});
        ramp(1'b0);
        @(posedge sys_clk);
        cmp.thermalHot <= 1'b1;
        for (n = 0; n < 20 && faultLatched !== 1'b1; n++) @(negedge sys_clk);
        chk("thermal", 1, 32'(n <= 8));
        repeat (3) @(negedge sys_clk);
        chk("thOff", 0, 32'(boostEnable | sourceSideSwitchOn | drainSideSwitchOn));
        conclude();
    end
endmodule : pss_sequencer_tb_top
`default_nettype wire
